//--- src/rscd_map.vh
// constants for the reset strap capture and address decode block
`ifndef RSCD_MAP_VH
`define RSCD_MAP_VH
`define RSCD_SEG_LSB 11
`define RSCD_SEG_MSB 12
`define RSCD_CLK_LSB 13
`define RSCD_CLK_MSB 15
`define RSCD_BOOT_BIT 4
`define RSCD_PORT_DEFAULT 16'hFFFF
`define RSCD_SEG_A16_A17 2'b11
`define RSCD_SEG_A16_A19 2'b00
`define RSCD_SEG_A16_A21 2'b10
`define RSCD_SEG_NONE 2'b01
`define RSCD_LINES_2 3'h2
`define RSCD_LINES_4 3'h4
`define RSCD_LINES_6 3'h6
`define RSCD_LINES_0 3'h0
`define RSCD_CLK_X4 3'b111
`define RSCD_CLK_X3 3'b110
`define RSCD_CLK_X2 3'b101
`define RSCD_CLK_X5 3'b100
`define RSCD_CLK_DIRECT 3'b011
`define RSCD_MUL_X4 3'h4
`define RSCD_MUL_X3 3'h3
`define RSCD_MUL_X2 3'h2
`define RSCD_MUL_X5 3'h5
`define RSCD_MUL_X1 3'h1
`define RSCD_START_ADDR 22'h00_0000
`define RSCD_SPLIT_4M 22'h20_0000
`define RSCD_SPLIT_1M 22'h08_0000
`define RSCD_LIMIT_1M 22'h10_0000
`define RSCD_IO_BASE 22'h00_8000
`define RSCD_IO_AREA_BITS 13
`define RSCD_IO_AREAS 3'h4
`define RSCD_FLASH_MIRROR_MASK 22'h03_FFFF
`define RSCD_RESET_CYCLES 4'h8
`endif

//--- src/rscd_strap_decode.v
// reset strap capture, clock/segment decode and memory model address decode
`timescale 1ns/1ps
`include "rscd_map.vh"

// Functional notes
// [RULE1] sample all configuration port pins once at end of internal reset
// [RULE2] enable pull-ups on configuration port while in reset
// [RULE3] board pulls a pin low during reset to pick non-default option
// [RULE4] board keeps reserved and fixed pins high during reset
// [RULE5] segment line count comes from port bits 11 and 12
// [RULE6] decode: 11=A16-17, 00=A16-19, bit11 low only=A16-21, bit12 low only=none
// [RULE7] clock source and multiplier come from port bits 13 to 15
// [RULE8] decode: all high x4, 13 low x3, 14 low x2, both x5, 15 low direct
// [RULE9] bootstrap pin low at reset starts the bootstrap loader
// [RULE10] jumper open gives model 1, jumper closed gives model 0
// [RULE11] model 1 without bootstrap starts from Flash at address zero
// [RULE12] model 0 without bootstrap starts from external RAM at address zero
// [RULE13] with CAN on top address lines, decodable space is at most 1 MB
// [RULE14] without CAN the full 4 MB linear space is decoded
// [RULE15] four separate 8 kB I/O areas exist in both models
// [RULE16] 256 kB of Flash is mirrored in the ROM area
// [RULE17] extended decode uses A20 for chip selects, excluding CAN on it; the code splits ram and flash on A21 instead
// [RULE18] 4 MB with jumper closed: RAM 0 to 1F:FFFF, Flash above
// [RULE19] chip-select disable jumper suppresses every chip select
// [RULE20] sampled values hold stable until the next reset
module rscd_strap_decode (
  input wire CLK_SYS,
  input wire RST_N,
  input wire [15:0] CONFIG_PORT_IN,
  input wire MEMORY_MODEL_JUMPER,
  input wire CHIP_SELECT_DISABLE_JUMPER,
  input wire CAN_ON_ADDRESS_LINES,
  input wire ADDR_VALID,
  input wire [21:0] ADDR,
  output reg CONFIG_PULLUP_EN,
  output reg CONFIG_DONE,
  output reg [15:0] CONFIG_SAMPLED,
  output reg [1:0] SEGMENT_LINE_COUNT_SELECT,
  output reg [2:0] SEGMENT_LINES_ACTIVE,
  output reg [2:0] CLOCK_SOURCE_SELECT,
  output reg CLOCK_FROM_PLL,
  output reg [2:0] CLOCK_MULTIPLIER,
  output reg BOOTSTRAP_LOADER_SELECT,
  output reg MEMORY_MODEL,
  output reg START_FROM_FLASH,
  output reg [21:0] START_ADDRESS,
  output reg CS_FLASH_N,
  output reg CS_RAM_N,
  output reg [3:0] CS_IO_N,
  output reg ADDR_OUT_OF_RANGE,
  output reg [19:0] FLASH_OFFSET
);

  ////////////////////////////////////////////////////////////////////////////
  // decode helpers

  function [2:0] seg_lines;
    input [1:0] sel;
    begin
      case (sel)
        `RSCD_SEG_A16_A17: seg_lines = `RSCD_LINES_2;
        `RSCD_SEG_A16_A19: seg_lines = `RSCD_LINES_4;
        `RSCD_SEG_A16_A21: seg_lines = `RSCD_LINES_6;
        default: seg_lines = `RSCD_LINES_0;
      endcase
    end
  endfunction

  function [2:0] clk_mul;
    input [2:0] sel;
    begin
      case (sel)
        `RSCD_CLK_X4: clk_mul = `RSCD_MUL_X4;
        `RSCD_CLK_X3: clk_mul = `RSCD_MUL_X3;
        `RSCD_CLK_X2: clk_mul = `RSCD_MUL_X2;
        `RSCD_CLK_X5: clk_mul = `RSCD_MUL_X5;
        `RSCD_CLK_DIRECT: clk_mul = `RSCD_MUL_X1;
        // undocumented codes fall back to the default pll setting
        default: clk_mul = `RSCD_MUL_X4;
      endcase
    end
  endfunction

  // the oscillator feeds the cpu directly only for the one direct code
  function pll_used;
    input [2:0] sel;
    begin
      pll_used = (sel != `RSCD_CLK_DIRECT); // see [RULE8]
    end
  endfunction

  // can on A20/A21 leaves only 1 MB, so the split drops to 512 kB
  function [21:0] split_point;
    input can_on;
    begin
      if (can_on)
        split_point = `RSCD_SPLIT_1M; // see [RULE13]
      else
        split_point = `RSCD_SPLIT_4M; // see [RULE14]
    end
  endfunction

  // with can on the top lines nothing past the first megabyte is decoded
  function beyond_limit;
    input can_on;
    input [21:0] addr;
    begin
      beyond_limit = can_on && (addr >= `RSCD_LIMIT_1M); // see [RULE13]
    end
  endfunction

  // compare equal widths so the upper base bits cannot be dropped
  function io_hit;
    input [21:0] addr;
    reg [21:0] base;
    begin
      base = `RSCD_IO_BASE;
      io_hit = (addr[21:`RSCD_IO_AREA_BITS + 2] == base[21:`RSCD_IO_AREA_BITS + 2]);
    end
  endfunction

  // one select per 8 kB window
  function [3:0] io_select;
    input [1:0] idx;
    begin
      case (idx)
        2'h0: io_select = 4'h1;
        2'h1: io_select = 4'h2;
        2'h2: io_select = 4'h4;
        default: io_select = 4'h8;
      endcase
    end
  endfunction

  // only 256 kB of flash is visible; higher rom addresses alias onto it
  function [19:0] mirror_offset;
    input [21:0] addr;
    reg [21:0] masked;
    begin
      masked = addr & `RSCD_FLASH_MIRROR_MASK;
      mirror_offset = masked[19:0];
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // internal reset sequence: fixed count after release, then one capture

  localparam ST_RESET = 3'b001;
  localparam ST_CAPTURE = 3'b010;
  localparam ST_RUN = 3'b100;

  reg [2:0] state;
  reg [2:0] next_state;
  reg [3:0] rst_count;

  always @*
  begin
    case (state)
      ST_RESET:
      begin
        // capture follows the last counting edge
        if (rst_count == `RSCD_RESET_CYCLES - 4'h1)
          next_state = ST_CAPTURE;
        else
          next_state = ST_RESET;
      end
      ST_CAPTURE: next_state = ST_RUN;
      ST_RUN: next_state = ST_RUN; // see [RULE20]
      default: next_state = ST_RESET;
    endcase
  end

  always @(posedge CLK_SYS or negedge RST_N)
  begin
    if (!RST_N)
    begin
      state <= ST_RESET;
      rst_count <= 4'h0;
    end
    else
    begin
      state <= next_state;
      if (state == ST_RESET)
        rst_count <= rst_count + 4'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // strap capture; registers reset to the pulled-up default levels

  wire [15:0] p = CONFIG_PORT_IN;
  wire [1:0] seg_sel = p[`RSCD_SEG_MSB:`RSCD_SEG_LSB]; // see [RULE5]
  wire [2:0] clk_sel = p[`RSCD_CLK_MSB:`RSCD_CLK_LSB]; // see [RULE7]

  always @(posedge CLK_SYS or negedge RST_N)
  begin
    if (!RST_N)
    begin
      CONFIG_PULLUP_EN <= 1'b1; // see [RULE2]
      CONFIG_DONE <= 1'b0;
      CONFIG_SAMPLED <= `RSCD_PORT_DEFAULT;
      SEGMENT_LINE_COUNT_SELECT <= 2'b11;
      SEGMENT_LINES_ACTIVE <= `RSCD_LINES_2;
      CLOCK_SOURCE_SELECT <= `RSCD_CLK_X4;
      CLOCK_FROM_PLL <= 1'b1;
      CLOCK_MULTIPLIER <= `RSCD_MUL_X4;
      BOOTSTRAP_LOADER_SELECT <= 1'b0;
      MEMORY_MODEL <= 1'b1;
      START_FROM_FLASH <= 1'b1;
      START_ADDRESS <= `RSCD_START_ADDR;
    end
    else if (state == ST_CAPTURE) // see [RULE1]
    begin
      CONFIG_PULLUP_EN <= 1'b0;
      CONFIG_DONE <= 1'b1;
      CONFIG_SAMPLED <= p;
      SEGMENT_LINE_COUNT_SELECT <= seg_sel;
      SEGMENT_LINES_ACTIVE <= seg_lines(seg_sel); // see [RULE6]
      CLOCK_SOURCE_SELECT <= clk_sel;
      CLOCK_FROM_PLL <= pll_used(clk_sel); // see [RULE8]
      CLOCK_MULTIPLIER <= clk_mul(clk_sel); // see [RULE8]
      BOOTSTRAP_LOADER_SELECT <= ~p[`RSCD_BOOT_BIT]; // see [RULE9]
      // open jumper reads high and selects model 1
      MEMORY_MODEL <= MEMORY_MODEL_JUMPER; // see [RULE10]
      // bootstrap loads into ram, so flash start only without it
      START_FROM_FLASH <= MEMORY_MODEL_JUMPER & p[`RSCD_BOOT_BIT]; // see [RULE11] [RULE12]
      START_ADDRESS <= `RSCD_START_ADDR; // see [RULE11] [RULE12]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // address decode; registered so every output leaves a flip-flop
  // model 1 puts flash below the split and ram above it, model 0 swaps them;
  // the io windows win over both, so those addresses never reach ram or flash.
  // limitation: with can the split sits at 512 kB, capping each half there.

  reg next_cs_flash;
  reg next_cs_ram;
  reg [3:0] next_cs_io;
  reg next_oor;
  reg in_io;
  reg low_half;
  reg [21:0] split;

  always @*
  begin
    next_cs_flash = 1'b0;
    next_cs_ram = 1'b0;
    next_cs_io = 4'h0;
    next_oor = 1'b0;
    in_io = 1'b0;
    low_half = 1'b0;
    split = split_point(CAN_ON_ADDRESS_LINES); // see [RULE13] [RULE14]
    if (ADDR_VALID && CONFIG_DONE)
    begin
      if (beyond_limit(CAN_ON_ADDRESS_LINES, ADDR))
        next_oor = 1'b1; // see [RULE13]
      else
      begin
        // four consecutive 8 kB windows above the io base
        in_io = io_hit(ADDR); // see [RULE15]
        if (in_io)
          next_cs_io = io_select(ADDR[`RSCD_IO_AREA_BITS + 1:`RSCD_IO_AREA_BITS]); // see [RULE15]
        else
        begin
          // A21 alone decides the compare for the 4 MB split
          low_half = (ADDR < split); // see [RULE17]
          if (MEMORY_MODEL)
          begin
            next_cs_flash = low_half;
            next_cs_ram = ~low_half;
          end
          else
          begin
            next_cs_ram = low_half; // see [RULE18]
            next_cs_flash = ~low_half; // see [RULE18]
          end
        end
      end
    end
    if (CHIP_SELECT_DISABLE_JUMPER)
    begin
      next_cs_flash = 1'b0; // see [RULE19]
      next_cs_ram = 1'b0; // see [RULE19]
      next_cs_io = 4'h0; // see [RULE19]
    end
  end

  always @(posedge CLK_SYS or negedge RST_N)
  begin
    if (!RST_N)
    begin
      CS_FLASH_N <= 1'b1;
      CS_RAM_N <= 1'b1;
      CS_IO_N <= 4'hF;
      ADDR_OUT_OF_RANGE <= 1'b0;
      FLASH_OFFSET <= 20'h0_0000;
    end
    else
    begin
      CS_FLASH_N <= ~next_cs_flash;
      CS_RAM_N <= ~next_cs_ram;
      CS_IO_N <= ~next_cs_io;
      ADDR_OUT_OF_RANGE <= next_oor;
      // the offset follows every address so it is ready with the flash select
      FLASH_OFFSET <= mirror_offset(ADDR); // see [RULE16]
    end
  end

endmodule

//--- test/rscd_board.sv
// board strap resistors and post-reset port activity model
`timescale 1ns/1ps
module rscd_board (
  input wire clk,
  input wire pullup_en,
  input wire [15:0] pull_down,
  output wire [15:0] port
);
  reg [15:0] busy = 16'h5A5A;
  // after reset the port is bus i/o, so it shows a moving pattern
  always @(posedge clk) busy <= ~busy + 16'h0001;
  assign port = pullup_en ? ~pull_down : busy;
endmodule

//--- test/rscd_assertions.sv
// checker for strap capture and address decode
`timescale 1ns/1ps
module rscd_assertions (
  input wire CLK_SYS,
  input wire RST_N,
  input wire [15:0] CONFIG_PORT_IN,
  input wire CHIP_SELECT_DISABLE_JUMPER,
  input wire CAN_ON_ADDRESS_LINES,
  input wire ADDR_VALID,
  input wire [21:0] ADDR,
  input wire CONFIG_PULLUP_EN,
  input wire CONFIG_DONE,
  input wire [15:0] CONFIG_SAMPLED,
  input wire [1:0] SEGMENT_LINE_COUNT_SELECT,
  input wire [2:0] CLOCK_SOURCE_SELECT,
  input wire BOOTSTRAP_LOADER_SELECT,
  input wire MEMORY_MODEL,
  input wire START_FROM_FLASH,
  input wire CS_FLASH_N,
  input wire CS_RAM_N,
  input wire [3:0] CS_IO_N
);
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (!RST_N);
  sequence s_req;
    CONFIG_DONE && ADDR_VALID && !CHIP_SELECT_DISABLE_JUMPER;
  endsequence
  sequence s_idle;
    CS_FLASH_N && CS_RAM_N && (CS_IO_N == 4'hF);
  endsequence
  AST_CAPTURE: assert property ($rose(CONFIG_DONE) |-> CONFIG_SAMPLED == $past(CONFIG_PORT_IN))
    else $error("captured straps differ from port");
  AST_PULLUP: assert property (CONFIG_PULLUP_EN == !CONFIG_DONE)
    else $error("pull-up enable wrong");
  AST_SEG: assert property (CONFIG_DONE |-> SEGMENT_LINE_COUNT_SELECT == CONFIG_SAMPLED[12:11])
    else $error("segment select not from bits 12:11");
  AST_CLK: assert property (CONFIG_DONE |-> CLOCK_SOURCE_SELECT == CONFIG_SAMPLED[15:13])
    else $error("clock select not from bits 15:13");
  AST_BOOT: assert property (CONFIG_DONE |-> BOOTSTRAP_LOADER_SELECT == !CONFIG_SAMPLED[4])
    else $error("bootstrap select wrong");
  AST_HOLD: assert property (CONFIG_DONE && $past(CONFIG_DONE) |-> $stable(CONFIG_SAMPLED))
    else $error("captured straps changed");
  AST_FLASH0: assert property (s_req ##0 MEMORY_MODEL && ADDR == 22'h00_0000 |=> !CS_FLASH_N)
    else $error("no flash select at zero");
  AST_CSDIS: assert property (CHIP_SELECT_DISABLE_JUMPER |=> s_idle)
    else $error("chip select while disabled");
  AST_CAN: assert property (s_req ##0 CAN_ON_ADDRESS_LINES && ADDR >= 22'h10_0000 |=> s_idle)
    else $error("select above 1 MB with CAN");
endmodule
bind rscd_strap_decode rscd_assertions rscd_assertions_inst (
  .CLK_SYS(CLK_SYS), .RST_N(RST_N), .CONFIG_PORT_IN(CONFIG_PORT_IN),
  .CHIP_SELECT_DISABLE_JUMPER(CHIP_SELECT_DISABLE_JUMPER),
  .CAN_ON_ADDRESS_LINES(CAN_ON_ADDRESS_LINES), .ADDR_VALID(ADDR_VALID), .ADDR(ADDR),
  .CONFIG_PULLUP_EN(CONFIG_PULLUP_EN), .CONFIG_DONE(CONFIG_DONE),
  .CONFIG_SAMPLED(CONFIG_SAMPLED), .SEGMENT_LINE_COUNT_SELECT(SEGMENT_LINE_COUNT_SELECT),
  .CLOCK_SOURCE_SELECT(CLOCK_SOURCE_SELECT), .BOOTSTRAP_LOADER_SELECT(BOOTSTRAP_LOADER_SELECT),
  .MEMORY_MODEL(MEMORY_MODEL), .START_FROM_FLASH(START_FROM_FLASH),
  .CS_FLASH_N(CS_FLASH_N), .CS_RAM_N(CS_RAM_N), .CS_IO_N(CS_IO_N));

//--- test/tb_rscd_strap_decode.sv
// self-checking bench for strap capture and address decode
`timescale 1ns/1ps
module tb_rscd_strap_decode;
  reg CLK_SYS = 1'b0;
  reg RST_N = 1'b0;
  reg MEMORY_MODEL_JUMPER = 1'b1;
  reg CHIP_SELECT_DISABLE_JUMPER = 1'b0;
  reg CAN_ON_ADDRESS_LINES = 1'b0;
  reg ADDR_VALID = 1'b0;
  reg [21:0] ADDR = 22'h00_0000;
  reg [15:0] pull_down = 16'h0000;
  wire [15:0] CONFIG_PORT_IN, CONFIG_SAMPLED;
  wire [1:0] SEGMENT_LINE_COUNT_SELECT;
  wire [2:0] SEGMENT_LINES_ACTIVE, CLOCK_SOURCE_SELECT, CLOCK_MULTIPLIER;
  wire CONFIG_PULLUP_EN, CONFIG_DONE, CLOCK_FROM_PLL, BOOTSTRAP_LOADER_SELECT, MEMORY_MODEL;
  wire START_FROM_FLASH, CS_FLASH_N, CS_RAM_N, ADDR_OUT_OF_RANGE;
  wire [21:0] START_ADDRESS;
  wire [3:0] CS_IO_N;
  wire [19:0] FLASH_OFFSET;
  integer failures = 0, cmp_count = 0, cycles = 0, i, n;
  reg [24:0] rows [0:4];
  rscd_strap_decode rscd_strap_decode_inst (.CLK_SYS(CLK_SYS), .RST_N(RST_N),
    .CONFIG_PORT_IN(CONFIG_PORT_IN), .MEMORY_MODEL_JUMPER(MEMORY_MODEL_JUMPER),
    .CHIP_SELECT_DISABLE_JUMPER(CHIP_SELECT_DISABLE_JUMPER),
    .CAN_ON_ADDRESS_LINES(CAN_ON_ADDRESS_LINES), .ADDR_VALID(ADDR_VALID), .ADDR(ADDR),
    .CONFIG_PULLUP_EN(CONFIG_PULLUP_EN), .CONFIG_DONE(CONFIG_DONE),
    .CONFIG_SAMPLED(CONFIG_SAMPLED), .SEGMENT_LINE_COUNT_SELECT(SEGMENT_LINE_COUNT_SELECT),
    .SEGMENT_LINES_ACTIVE(SEGMENT_LINES_ACTIVE), .CLOCK_SOURCE_SELECT(CLOCK_SOURCE_SELECT),
    .CLOCK_FROM_PLL(CLOCK_FROM_PLL), .CLOCK_MULTIPLIER(CLOCK_MULTIPLIER),
    .BOOTSTRAP_LOADER_SELECT(BOOTSTRAP_LOADER_SELECT), .MEMORY_MODEL(MEMORY_MODEL),
    .START_FROM_FLASH(START_FROM_FLASH), .START_ADDRESS(START_ADDRESS),
    .CS_FLASH_N(CS_FLASH_N), .CS_RAM_N(CS_RAM_N), .CS_IO_N(CS_IO_N),
    .ADDR_OUT_OF_RANGE(ADDR_OUT_OF_RANGE), .FLASH_OFFSET(FLASH_OFFSET));
  rscd_board rscd_board_inst (.clk(CLK_SYS), .pullup_en(CONFIG_PULLUP_EN),
    .pull_down(pull_down), .port(CONFIG_PORT_IN));
  initial forever #50 CLK_SYS = ~CLK_SYS;
  task chk(input [21:0] seen, input [21:0] exp);
  begin
    cmp_count = cmp_count + 1;
    if (seen !== exp)
    begin
      failures = failures + 1;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  end
  endtask
  task end_of_test;
  begin
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  end
  endtask
  // reset with given pull-downs; the edge count to capture is checked too
  task strap(input [15:0] pd, input jmp);
  begin
    @(posedge CLK_SYS);
    RST_N <= 1'b0;
    pull_down <= pd;
    MEMORY_MODEL_JUMPER <= jmp;
    repeat (5) @(posedge CLK_SYS);
    chk({CONFIG_PULLUP_EN, CONFIG_DONE}, 2'b10);
    RST_N <= 1'b1;
    n = 0;
    while (CONFIG_DONE !== 1'b1 && n < 20)
    begin
      @(posedge CLK_SYS);
      #1;
      n = n + 1;
    end
    chk(n, 9);
    chk({CONFIG_PULLUP_EN, CONFIG_DONE}, 2'b01);
  end
  endtask
  // m[0] routes CAN to the top lines, m[1] closes the disable jumper
  task dec(input [21:0] a, input [1:0] m, input [6:0] exp);
  begin
    @(posedge CLK_SYS);
    ADDR <= a;
    ADDR_VALID <= 1'b1;
    {CHIP_SELECT_DISABLE_JUMPER, CAN_ON_ADDRESS_LINES} <= m;
    @(posedge CLK_SYS);
    #1;
    chk({ADDR_OUT_OF_RANGE, CS_FLASH_N, CS_RAM_N, CS_IO_N}, exp);
  end
  endtask
  always @(posedge CLK_SYS)
  begin
    cycles = cycles + 1;
    if (cycles == 1000)
    begin
      failures = failures + 1;
      end_of_test;
    end
  end
  initial
  begin
    // pull-downs only on configurable pins
    rows[0] = {16'h0000, 1'b1, 3'h2, 3'h4, 1'b1, 1'b0};
    rows[1] = {16'h3810, 1'b1, 3'h4, 3'h3, 1'b1, 1'b1};
    rows[2] = {16'h4800, 1'b0, 3'h6, 3'h2, 1'b1, 1'b0};
    rows[3] = {16'h7000, 1'b1, 3'h0, 3'h5, 1'b1, 1'b0};
    rows[4] = {16'h8000, 1'b0, 3'h2, 3'h1, 1'b0, 1'b0};
    for (i = 0; i < 5; i = i + 1)
    begin
      strap(rows[i][24:9], rows[i][8]);
      chk(CONFIG_SAMPLED, {6'h00, ~rows[i][24:9]});
      chk(SEGMENT_LINE_COUNT_SELECT, {20'h0_0000, ~rows[i][21:20]});
      chk(CLOCK_SOURCE_SELECT, {19'h0_0000, ~rows[i][24:22]});
      chk(SEGMENT_LINES_ACTIVE, rows[i][7:5]);
      chk(CLOCK_MULTIPLIER, rows[i][4:2]);
      chk(CLOCK_FROM_PLL, rows[i][1]);
      chk(BOOTSTRAP_LOADER_SELECT, rows[i][0]);
      chk(MEMORY_MODEL, rows[i][8]);
      chk(START_FROM_FLASH, rows[i][8] & ~rows[i][0]);
    end
    dec(22'h00_0000, 2'b00, 7'b0101111);
    dec(22'h1F_FFFF, 2'b00, 7'b0101111);
    dec(22'h20_0000, 2'b00, 7'b0011111);
    strap(16'h0000, 1'b1);
    chk(START_ADDRESS, 22'h00_0000);
    dec(22'h00_0000, 2'b00, 7'b0011111);
    dec(22'h3F_FFFF, 2'b00, 7'b0101111);
    dec(22'h00_A000, 2'b00, 7'b0111101);
    dec(22'h00_E000, 2'b00, 7'b0110111);
    dec(22'h07_FFFF, 2'b01, 7'b0011111);
    dec(22'h08_0000, 2'b01, 7'b0101111);
    dec(22'h10_0000, 2'b01, 7'b1111111);
    dec(22'h00_0000, 2'b10, 7'b0111111);
    dec(22'h05_1234, 2'b00, 7'b0011111);
    chk(FLASH_OFFSET, 22'h01_1234);
    chk(CONFIG_SAMPLED, 16'hFFFF);
    end_of_test;
  end
endmodule
